/* File: hw/sfl_pkg.sv */
// Constants and types for the supply fault-limit and status register bank.
// Assumes one 125 MHz clock and a command port already stripped of bus framing.
package sfl_pkg;
  // Clock and restart timing
  localparam int unsigned CLK_FREQ_MHZ = 125;
  localparam int unsigned HICCUP_TIME_US = 1000;
  localparam int unsigned TMR_W = 24;

  // Command codes
  localparam logic [7:0] OFS_VOUT_OV_WARN = 8'h42;
  localparam logic [7:0] OFS_VOUT_UV_WARN = 8'h43;
  localparam logic [7:0] OFS_VOUT_UV_FAULT = 8'h44;
  localparam logic [7:0] OFS_VOUT_UV_ACT = 8'h45;
  localparam logic [7:0] OFS_OC_FAULT = 8'h46;
  localparam logic [7:0] OFS_OC_ACT = 8'h47;
  localparam logic [7:0] OFS_OC_WARN = 8'h4A;
  localparam logic [7:0] OFS_OT_FAULT = 8'h4F;
  localparam logic [7:0] OFS_OT_ACT = 8'h50;
  localparam logic [7:0] OFS_OT_WARN = 8'h51;
  localparam logic [7:0] OFS_VIN_OV_FAULT = 8'h55;
  localparam logic [7:0] OFS_VIN_OV_ACT = 8'h56;
  localparam logic [7:0] OFS_VIN_UV_WARN = 8'h58;
  localparam logic [7:0] OFS_VIN_UV_FAULT = 8'h59;
  localparam logic [7:0] OFS_VIN_UV_ACT = 8'h5A;
  localparam logic [7:0] OFS_STATUS_BYTE = 8'h78;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h79;
  localparam logic [7:0] OFS_STATUS_VOUT = 8'h7A;
  localparam logic [7:0] OFS_OUTPUT_CURRENT_STATUS = 8'h7B;
  localparam logic [7:0] OFS_STATUS_INPUT = 8'h7C;
  localparam logic [7:0] OFS_STATUS_TEMP = 8'h7D;
  localparam logic [7:0] OFS_COMMUNICATION_STATUS = 8'h7E;
  localparam logic [7:0] OFS_STATUS_FAN = 8'h81;

  // Defaults, fixed input limits and read error word: output volts in 2^-8 steps, input volts as whole volts
  localparam logic [15:0] VOUT_OV_WARN_DEF = 16'hA100;
  localparam logic [15:0] VOUT_UV_WARN_DEF = 16'h5900;
  localparam logic [15:0] VOUT_UV_FAULT_DEF = 16'h5500;
  localparam logic [15:0] VIN_OV_FAULT_LIM = 16'h021C;
  localparam logic [15:0] VIN_UV_WARN_DEF = 16'h0154;
  localparam logic [15:0] VIN_UV_FAULT_LIM = 16'h0136;
  localparam logic [15:0] READ_ERR_DATA = 16'hFFFF;

  // Response codes
  localparam logic [7:0] UV_ACT_LATCH = 8'h80;
  localparam logic [7:0] UV_ACT_RESTART = 8'hC0;
  localparam logic [7:0] OC_ACT_HICCUP = 8'hF8;
  localparam logic [7:0] OC_ACT_LATCH = 8'hC0;
  localparam logic [7:0] OT_ACT_HICCUP = 8'hC0;
  localparam logic [7:0] OT_ACT_LATCH = 8'h80;
  localparam logic [7:0] VIN_ACT_RESTART = 8'hC0;

  typedef enum logic [2:0] {
    ST_ON = 3'b001,
    ST_HICCUP = 3'b010,
    ST_LATCHED = 3'b100
  } sfl_mode_t;

  // Status byte layouts, most significant bit first
  typedef struct packed {
    logic rsvd7, off, vout_ov, iout_oc, vin_uv, temp, comm_memory_logic_fault, none;
  } sfl_sum_t;
  typedef struct packed {
    logic vout, iout, input_any, mfr, pg_n, fans, other, unknown;
  } sfl_hi_t;
  typedef struct packed {
    logic ov_fault, ov_warn, uv_warn, uv_fault;
    logic [3:0] rsvd;
  } sfl_vout_st_t;
  typedef struct packed {
    logic oc_fault, rsvd6, oc_warn, rsvd4, share_fault, pwr_limit;
    logic [1:0] rsvd;
  } sfl_iout_st_t;
  typedef struct packed {
    logic ov_fault, ov_warn, uv_warn, uv_fault, off_low_in, iin_oc;
    logic [1:0] rsvd;
  } sfl_in_st_t;
  typedef struct packed {
    logic ot_fault, ot_warn;
    logic [5:0] rsvd;
  } sfl_temp_st_t;
  typedef struct packed {
    logic bad_cmd, bad_data, pec_fail;
    logic [2:0] rsvd;
    logic other;
    logic rsvd0;
  } sfl_cml_st_t;
  typedef struct packed {
    logic fan1_fault, fan2_fault;
    logic [1:0] rsvd54;
    logic fan1_ovr, fan2_ovr;
    logic [1:0] rsvd;
  } sfl_fan_st_t;

  typedef struct packed {
    sfl_mode_t mode;
    logic [TMR_W-1:0] timer;
    logic [15:0] ovw_lim, uvw_lim, uvf_lim;
    logic [7:0] uv_act;
    logic [15:0] ocf_lo, ocf_hi, ocw_lo, ocw_hi;
    logic [7:0] oc_act;
    logic [15:0] otf_lim, otw_lim;
    logic [7:0] ot_act;
    logic [15:0] vinuvw_lim;
    sfl_vout_st_t vout_st;
    sfl_iout_st_t iout_st;
    sfl_in_st_t in_st;
    sfl_temp_st_t temp_st;
    sfl_cml_st_t cml_st;
    sfl_fan_st_t fan_st;
    logic [15:0] rd_data;
    logic rd_valid;
    logic alert_n;
    logic out_en;
    logic nv_we;
    logic [7:0] nv_code;
    logic [15:0] nv_data;
  } sfl_regs_t;
endpackage

/* File: hw/sfl_bank.sv */
// Fault-limit, fault-response and status register bank of a managed supply.
// Assumes framed commands arrive as one-cycle strobes and measurements are synchronous.
//
// Contract
// - Output overvoltage warning limit, default 161 V; exceeding it asserts alert.
// - Output undervoltage warning limit, default 89 V; dropping below while the output is on asserts alert.
// - Output below 85 V default fault limit shuts down, unless input was lost.
// - Output undervoltage response takes only 0x80 or 0xC0; resets to 0xC0.
// - Overcurrent limits kept per input range; a write changes present range only.
// - Overcurrent response resets to hiccup 0xF8, alternative latch 0xC0, both ranges.
// - Secondary temperature above fault limit triggers the configured response.
// - Overtemperature response resets to hiccup 0xC0, alternative latch 0x80.
// - Secondary temperature above warning limit raises overtemperature warning.
// - Input above fixed 540 V AC shuts down; host cannot change limit.
// - Input overvoltage response fixed at restart 0xC0, not host changeable.
// - Input undervoltage warning defaults 340 V AC; raising accepted, lowering rejected.
// - Input below fixed 310 V AC shuts down; fixed restart 0xC0 response.
// - Changeable limits and responses can be saved to non-volatile storage.
// - Summary status byte is read-only, resets zero, carries the summary flags.
// - Status word: summary byte low, group flags in high byte.
// - Fan status: two fan faults and two speed-override flags.
// - Successful restart from latched-off clears all status registers.
`timescale 1ns/1ps
module sfl_bank
  import sfl_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = HICCUP_TIME_US * CLK_FREQ_MHZ,
  parameter logic [15:0] OC_FAULT_LO_DEF = 16'h0000,
  parameter logic [15:0] OC_FAULT_HI_DEF = 16'h0000,
  parameter logic [15:0] OC_WARN_LO_DEF = 16'h0000,
  parameter logic [15:0] OC_WARN_HI_DEF = 16'h0000,
  parameter logic [15:0] OT_FAULT_DEF = 16'h0000,
  parameter logic [15:0] OT_WARN_DEF = 16'h0000
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // Command port
  input wire logic [7:0] CMD_CODE_I,
  input wire logic WR_EN_I,
  input wire logic [15:0] WR_DATA_I,
  input wire logic RD_EN_I,
  output logic [15:0] RD_DATA_O,
  output logic RD_VALID_O,
  // Non-volatile store and load
  input wire logic STORE_I,
  input wire logic NV_LOAD_I,
  output logic NV_WE_O,
  output logic [7:0] NV_CODE_O,
  output logic [15:0] NV_DATA_O,
  // Measurements
  input wire logic [15:0] VOUT_I,
  input wire logic [15:0] IOUT_I,
  input wire logic [15:0] TEMP_I,
  input wire logic [15:0] VIN_I,
  input wire logic HIGH_LINE_I,
  input wire logic AC_LOSS_I,
  // Conditions detected elsewhere
  input wire logic VOUT_OV_FAULT_I,
  input wire logic VIN_OV_WARN_I,
  input wire logic IIN_OC_FAULT_I,
  input wire logic SHARE_FAULT_I,
  input wire logic PWR_LIMIT_I,
  input wire logic PEC_FAIL_I,
  input wire logic COMM_OTHER_I,
  input wire logic FAN1_FAULT_I,
  input wire logic FAN2_FAULT_I,
  input wire logic FAN1_OVR_I,
  input wire logic FAN2_OVR_I,
  input wire logic RESTART_I,
  // Supply control
  output logic ALERT_N_O,
  output logic OUTPUT_EN_O
);

  localparam sfl_regs_t RST_VAL = '{
    mode: ST_ON, timer: '0,
    ovw_lim: VOUT_OV_WARN_DEF, uvw_lim: VOUT_UV_WARN_DEF, uvf_lim: VOUT_UV_FAULT_DEF,
    uv_act: UV_ACT_RESTART,
    ocf_lo: OC_FAULT_LO_DEF, ocf_hi: OC_FAULT_HI_DEF,
    ocw_lo: OC_WARN_LO_DEF, ocw_hi: OC_WARN_HI_DEF,
    oc_act: OC_ACT_HICCUP,
    otf_lim: OT_FAULT_DEF, otw_lim: OT_WARN_DEF, ot_act: OT_ACT_HICCUP,
    vinuvw_lim: VIN_UV_WARN_DEF,
    vout_st: '0, iout_st: '0, in_st: '0, temp_st: '0, cml_st: '0, fan_st: '0,
    rd_data: '0, rd_valid: 1'b0, alert_n: 1'b1, out_en: 1'b1,
    nv_we: 1'b0, nv_code: '0, nv_data: '0
  };

  sfl_regs_t q;
  sfl_regs_t d;

  // Live conditions
  logic on;
  logic vout_ov_warn, vout_uv_warn, vout_uv_fault;
  logic oc_fault, oc_warn, ot_fault, ot_warn;
  logic vin_ov_fault, vin_uv_fault, vin_uv_warn;
  logic shut, latch, clr, wr, bad_cmd, bad_data;
  sfl_sum_t sum;
  sfl_hi_t hi;

  assign on = (q.mode == ST_ON);
  assign vout_ov_warn = VOUT_I > q.ovw_lim;
  assign vout_uv_warn = on && (VOUT_I < q.uvw_lim);
  // A sagging output is expected when the input has gone away
  assign vout_uv_fault = on && (VOUT_I < q.uvf_lim) && !AC_LOSS_I && !vin_uv_fault;
  assign oc_fault = IOUT_I > (HIGH_LINE_I ? q.ocf_hi : q.ocf_lo);
  assign oc_warn = IOUT_I > (HIGH_LINE_I ? q.ocw_hi : q.ocw_lo);
  assign ot_fault = TEMP_I > q.otf_lim;
  assign ot_warn = TEMP_I > q.otw_lim;
  assign vin_ov_fault = VIN_I > VIN_OV_FAULT_LIM;
  assign vin_uv_fault = VIN_I < VIN_UV_FAULT_LIM;
  assign vin_uv_warn = VIN_I < q.vinuvw_lim;

  assign shut = on && (vout_uv_fault || oc_fault || ot_fault || vin_ov_fault || vin_uv_fault);
  assign latch = (vout_uv_fault && q.uv_act == UV_ACT_LATCH)
    || (oc_fault && q.oc_act == OC_ACT_LATCH)
    || (ot_fault && q.ot_act == OT_ACT_LATCH);
  assign clr = RESTART_I && (q.mode == ST_LATCHED);
  assign wr = WR_EN_I || NV_LOAD_I;

  // Summary views of the status bytes and the output state
  always_comb begin
    hi = '0;
    hi.vout = |q.vout_st;
    hi.iout = |q.iout_st;
    hi.input_any = |q.in_st;
    hi.pg_n = !on;
    hi.fans = |q.fan_st;
    sum = '0;
    sum.off = !on;
    sum.vout_ov = q.vout_st.ov_fault;
    sum.iout_oc = q.iout_st.oc_fault;
    sum.vin_uv = q.in_st.uv_fault;
    sum.temp = |q.temp_st;
    sum.comm_memory_logic_fault = |q.cml_st;
    sum.none = (|hi) && !(sum.off || sum.vout_ov || sum.iout_oc || sum.vin_uv
      || sum.temp || sum.comm_memory_logic_fault);
  end

  always_comb begin
    d = q;
    bad_cmd = 1'b0;
    bad_data = 1'b0;
    d.rd_valid = 1'b0;
    d.nv_we = 1'b0;

    // Writes and non-volatile loads share one acceptance path
    if (wr) begin
      case (CMD_CODE_I)
        OFS_VOUT_OV_WARN: d.ovw_lim = WR_DATA_I;
        OFS_VOUT_UV_WARN: d.uvw_lim = WR_DATA_I;
        OFS_VOUT_UV_FAULT: d.uvf_lim = WR_DATA_I;
        OFS_VOUT_UV_ACT: begin
          if (WR_DATA_I[7:0] == UV_ACT_LATCH || WR_DATA_I[7:0] == UV_ACT_RESTART) begin
            d.uv_act = WR_DATA_I[7:0];
          end else begin
            bad_data = 1'b1;
          end
        end
        OFS_OC_FAULT: begin
          if (HIGH_LINE_I) begin
            d.ocf_hi = WR_DATA_I;
          end else begin
            d.ocf_lo = WR_DATA_I;
          end
        end
        OFS_OC_WARN: begin
          if (HIGH_LINE_I) begin
            d.ocw_hi = WR_DATA_I;
          end else begin
            d.ocw_lo = WR_DATA_I;
          end
        end
        OFS_OC_ACT: begin
          if (WR_DATA_I[7:0] == OC_ACT_HICCUP || WR_DATA_I[7:0] == OC_ACT_LATCH) begin
            d.oc_act = WR_DATA_I[7:0];
          end else begin
            bad_data = 1'b1;
          end
        end
        OFS_OT_FAULT: d.otf_lim = WR_DATA_I;
        OFS_OT_WARN: d.otw_lim = WR_DATA_I;
        OFS_OT_ACT: begin
          if (WR_DATA_I[7:0] == OT_ACT_HICCUP || WR_DATA_I[7:0] == OT_ACT_LATCH) begin
            d.ot_act = WR_DATA_I[7:0];
          end else begin
            bad_data = 1'b1;
          end
        end
        OFS_VIN_UV_WARN: begin
          if (WR_DATA_I >= q.vinuvw_lim) begin
            d.vinuvw_lim = WR_DATA_I;
          end else begin
            bad_data = 1'b1;
          end
        end
        // Fixed input limits and status bytes fall here and are refused
        default: bad_cmd = 1'b1;
      endcase
    end

    // Save the present value of a changeable setting
    if (STORE_I) begin
      d.nv_we = 1'b1;
      d.nv_code = CMD_CODE_I;
      case (CMD_CODE_I)
        OFS_VOUT_OV_WARN: d.nv_data = q.ovw_lim;
        OFS_VOUT_UV_WARN: d.nv_data = q.uvw_lim;
        OFS_VOUT_UV_FAULT: d.nv_data = q.uvf_lim;
        OFS_VOUT_UV_ACT: d.nv_data = {8'h00, q.uv_act};
        OFS_OC_FAULT: d.nv_data = HIGH_LINE_I ? q.ocf_hi : q.ocf_lo;
        OFS_OC_WARN: d.nv_data = HIGH_LINE_I ? q.ocw_hi : q.ocw_lo;
        OFS_OC_ACT: d.nv_data = {8'h00, q.oc_act};
        OFS_OT_FAULT: d.nv_data = q.otf_lim;
        OFS_OT_WARN: d.nv_data = q.otw_lim;
        OFS_OT_ACT: d.nv_data = {8'h00, q.ot_act};
        OFS_VIN_UV_WARN: d.nv_data = q.vinuvw_lim;
        default: begin
          d.nv_we = 1'b0;
          bad_cmd = 1'b1;
        end
      endcase
    end

    // Reads answer one cycle later; unknown codes return all ones
    if (RD_EN_I) begin
      d.rd_valid = 1'b1;
      case (CMD_CODE_I)
        OFS_VOUT_OV_WARN: d.rd_data = q.ovw_lim;
        OFS_VOUT_UV_WARN: d.rd_data = q.uvw_lim;
        OFS_VOUT_UV_FAULT: d.rd_data = q.uvf_lim;
        OFS_VOUT_UV_ACT: d.rd_data = {8'h00, q.uv_act};
        OFS_OC_FAULT: d.rd_data = HIGH_LINE_I ? q.ocf_hi : q.ocf_lo;
        OFS_OC_WARN: d.rd_data = HIGH_LINE_I ? q.ocw_hi : q.ocw_lo;
        OFS_OC_ACT: d.rd_data = {8'h00, q.oc_act};
        OFS_OT_FAULT: d.rd_data = q.otf_lim;
        OFS_OT_WARN: d.rd_data = q.otw_lim;
        OFS_OT_ACT: d.rd_data = {8'h00, q.ot_act};
        OFS_VIN_OV_FAULT: d.rd_data = VIN_OV_FAULT_LIM;
        OFS_VIN_OV_ACT: d.rd_data = {8'h00, VIN_ACT_RESTART};
        OFS_VIN_UV_WARN: d.rd_data = q.vinuvw_lim;
        OFS_VIN_UV_FAULT: d.rd_data = VIN_UV_FAULT_LIM;
        OFS_VIN_UV_ACT: d.rd_data = {8'h00, VIN_ACT_RESTART};
        OFS_STATUS_BYTE: d.rd_data = {8'h00, sum};
        OFS_STATUS_WORD: d.rd_data = {hi, sum};
        OFS_STATUS_VOUT: d.rd_data = {8'h00, q.vout_st};
        OFS_OUTPUT_CURRENT_STATUS: d.rd_data = {8'h00, q.iout_st};
        OFS_STATUS_INPUT: d.rd_data = {8'h00, q.in_st};
        OFS_STATUS_TEMP: d.rd_data = {8'h00, q.temp_st};
        OFS_COMMUNICATION_STATUS: d.rd_data = {8'h00, q.cml_st};
        OFS_STATUS_FAN: d.rd_data = {8'h00, q.fan_st};
        default: begin
          d.rd_data = READ_ERR_DATA;
          bad_cmd = 1'b1;
        end
      endcase
    end

    // Output state machine
    case (q.mode)
      ST_ON: begin
        if (shut) begin
          d.mode = latch ? ST_LATCHED : ST_HICCUP;
          d.timer = TMR_W'(HICCUP_CYCLES - 1);
        end
      end
      ST_HICCUP: begin
        // Input faults restart only once the input is back in range
        if (q.timer != '0) begin
          d.timer = q.timer - 1'b1;
        end else if (!vin_ov_fault && !vin_uv_fault) begin
          d.mode = ST_ON;
        end
      end
      ST_LATCHED: begin
        if (RESTART_I) begin
          d.mode = ST_ON;
        end
      end
      default: d.mode = ST_LATCHED;
    endcase
    d.out_en = (d.mode == ST_ON);

    // Status bits, sticky except power limit and fan overrides: restart clears, a same-cycle event still sets
    if (clr) begin
      d.vout_st = '0;
      d.iout_st = '0;
      d.in_st = '0;
      d.temp_st = '0;
      d.cml_st = '0;
      d.fan_st = '0;
    end
    d.vout_st.ov_fault = d.vout_st.ov_fault | VOUT_OV_FAULT_I;
    d.vout_st.ov_warn = d.vout_st.ov_warn | vout_ov_warn;
    d.vout_st.uv_warn = d.vout_st.uv_warn | vout_uv_warn;
    d.vout_st.uv_fault = d.vout_st.uv_fault | vout_uv_fault;
    d.iout_st.oc_fault = d.iout_st.oc_fault | oc_fault;
    d.iout_st.oc_warn = d.iout_st.oc_warn | oc_warn;
    d.iout_st.share_fault = d.iout_st.share_fault | SHARE_FAULT_I;
    d.iout_st.pwr_limit = PWR_LIMIT_I;
    d.in_st.ov_fault = d.in_st.ov_fault | vin_ov_fault;
    d.in_st.ov_warn = d.in_st.ov_warn | VIN_OV_WARN_I;
    d.in_st.uv_warn = d.in_st.uv_warn | vin_uv_warn;
    d.in_st.uv_fault = d.in_st.uv_fault | vin_uv_fault;
    d.in_st.off_low_in = d.in_st.off_low_in | (on && vin_uv_fault);
    d.in_st.iin_oc = d.in_st.iin_oc | IIN_OC_FAULT_I;
    d.temp_st.ot_fault = d.temp_st.ot_fault | ot_fault;
    d.temp_st.ot_warn = d.temp_st.ot_warn | ot_warn;
    d.cml_st.bad_cmd = d.cml_st.bad_cmd | (bad_cmd && !NV_LOAD_I);
    d.cml_st.bad_data = d.cml_st.bad_data | (bad_data && !NV_LOAD_I);
    d.cml_st.pec_fail = d.cml_st.pec_fail | PEC_FAIL_I;
    d.cml_st.other = d.cml_st.other | COMM_OTHER_I;
    d.fan_st.fan1_fault = d.fan_st.fan1_fault | FAN1_FAULT_I;
    d.fan_st.fan2_fault = d.fan_st.fan2_fault | FAN2_FAULT_I;
    d.fan_st.fan1_ovr = FAN1_OVR_I;
    d.fan_st.fan2_ovr = FAN2_OVR_I;

    d.alert_n = !(|{d.vout_st, d.iout_st, d.in_st, d.temp_st, d.cml_st, d.fan_st});
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  assign RD_DATA_O = q.rd_data;
  assign RD_VALID_O = q.rd_valid;
  assign NV_WE_O = q.nv_we;
  assign NV_CODE_O = q.nv_code;
  assign NV_DATA_O = q.nv_data;
  assign ALERT_N_O = q.alert_n;
  assign OUTPUT_EN_O = q.out_en;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  AST_OV_WARN_ALERT: assert property (
    (VOUT_I > q.ovw_lim) |=> (q.vout_st.ov_warn && !ALERT_N_O))
    else $error("output overvoltage warning did not raise alert");
  AST_UV_WARN_ALERT: assert property (
    (on && VOUT_I < q.uvw_lim) |=> !ALERT_N_O)
    else $error("output undervoltage warning did not raise alert");
  AST_UV_FAULT_MASK: assert property (
    $rose(q.vout_st.uv_fault) |-> $past(!AC_LOSS_I))
    else $error("undervoltage fault recorded during input loss");
  AST_UV_ACT_LEGAL: assert property (
    q.uv_act == UV_ACT_LATCH || q.uv_act == UV_ACT_RESTART)
    else $error("illegal undervoltage response stored");
  AST_OC_RANGE: assert property (
    (wr && CMD_CODE_I == OFS_OC_FAULT && !HIGH_LINE_I) |=> $stable(q.ocf_hi))
    else $error("low-line write changed high-line limit");
  AST_OC_ACT_LEGAL: assert property (
    q.oc_act == OC_ACT_HICCUP || q.oc_act == OC_ACT_LATCH)
    else $error("illegal overcurrent response stored");
  AST_OT_SHUTDOWN: assert property (
    (on && TEMP_I > q.otf_lim) |=> (!OUTPUT_EN_O ##1 !OUTPUT_EN_O))
    else $error("overtemperature did not shut output");
  AST_OT_ACT_LEGAL: assert property (
    q.ot_act == OT_ACT_HICCUP || q.ot_act == OT_ACT_LATCH)
    else $error("illegal overtemperature response stored");
  AST_VIN_OV_FIXED: assert property (
    (RD_EN_I && CMD_CODE_I == OFS_VIN_OV_FAULT) |=> (RD_VALID_O && RD_DATA_O == VIN_OV_FAULT_LIM))
    else $error("input overvoltage limit read wrong");
  AST_VIN_UV_RAISE: assert property (
    1'b1 |=> q.vinuvw_lim >= $past(q.vinuvw_lim))
    else $error("input undervoltage warning limit was lowered");
  AST_STATUS_WORD: assert property (
    (RD_EN_I && CMD_CODE_I == OFS_STATUS_WORD) |=> RD_DATA_O == $past({hi, sum}))
    else $error("status word read wrong");
  AST_LATCH_RESTART: assert property (
    (q.mode == ST_LATCHED && RESTART_I) |=> (OUTPUT_EN_O && q.mode == ST_ON))
    else $error("restart from latched-off failed");
  AST_STICKY_OT_WARN: assert property (
    (q.temp_st.ot_warn && !RESTART_I) |=> q.temp_st.ot_warn)
    else $error("temperature warning lost without restart");

  COV_LATCH_OFF: cover property (on ##1 q.mode == ST_LATCHED);
  COV_HICCUP_BACK: cover property (q.mode == ST_HICCUP ##1 on);
  COV_BAD_DATA: cover property ($rose(q.cml_st.bad_data));
  COV_STORE: cover property (NV_WE_O);

endmodule

/* File: bench/sfl_host.sv */
// Host-side model that issues command-port strobes for the bench.
// Assumes one clock; strobes launch at a rising edge and are taken at the next.
`timescale 1ns/1ps
module sfl_host (
  // Clock and answer
  input wire logic clk_i,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  // Request
  output logic [7:0] code_o,
  output logic wr_o,
  output logic rd_o,
  output logic st_o,
  output logic [15:0] data_o
);
  initial begin
    {code_o, wr_o, rd_o, st_o, data_o} = '0;
  end
  // Write or store, held whole for the one taking edge
  task automatic cmd(input logic st, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_i);
    {code_o, data_o, st_o, wr_o} <= {c, d, st, ~st};
    @(posedge clk_i);
    {st_o, wr_o} <= 2'b00;
  endtask
  // Answer is taken just after the edge that launched it
  task automatic read(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk_i);
    {code_o, rd_o} <= {c, 1'b1};
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rd_valid_i ? rd_data_i : 16'hXXXX;
  endtask
endmodule

/* File: bench/sfl_bank_test.sv */
// Self-checking bench for the supply fault-limit and status bank.
// Assumes the host model drives the command port; bench drives measurements.
`timescale 1ns/1ps
module sfl_bank_test;
  import sfl_pkg::*;
  localparam int HC = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hl = 1'b0;
  logic restart = 1'b0;
  logic wr, rd, st, rv, nvwe, alert_n, out_en;
  logic [7:0] code, nvcode;
  logic [15:0] wd, rdat, nvdata, got, rnd;
  logic [15:0] vout = 16'h7D00;
  logic [15:0] temp = 16'h0020;
  logic [15:0] iout = 16'h0000;
  logic [15:0] vin = 16'h0170;
  logic [12:0] ev = 13'h0000;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 52393;
  logic [7:0] codes [19] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h47, 8'h50, 8'h55, 8'h56, 8'h58,
    8'h59, 8'h5A, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h81};
  always #4 clk = ~clk;
  sfl_host u_host (.clk_i(clk), .rd_valid_i(rv), .rd_data_i(rdat), .code_o(code), .wr_o(wr),
    .rd_o(rd), .st_o(st), .data_o(wd));
  sfl_bank #(.HICCUP_CYCLES(HC), .OC_FAULT_LO_DEF(16'h0100), .OC_FAULT_HI_DEF(16'h0200),
    .OC_WARN_LO_DEF(16'h00F0), .OT_FAULT_DEF(16'h0050),
    .OT_WARN_DEF(16'h0040)) u_dut (.MCLK_I(clk), .RESET_I(rst), .CMD_CODE_I(code),
    .WR_EN_I(wr), .WR_DATA_I(wd), .RD_EN_I(rd), .RD_DATA_O(rdat), .RD_VALID_O(rv),
    .STORE_I(st), .NV_LOAD_I(ev[11]), .NV_WE_O(nvwe), .NV_CODE_O(nvcode), .NV_DATA_O(nvdata),
    .VOUT_I(vout), .IOUT_I(iout), .TEMP_I(temp), .VIN_I(vin), .HIGH_LINE_I(hl),
    .AC_LOSS_I(ev[12]), .VOUT_OV_FAULT_I(ev[0]), .VIN_OV_WARN_I(ev[1]),
    .IIN_OC_FAULT_I(ev[2]), .SHARE_FAULT_I(ev[3]), .PWR_LIMIT_I(ev[4]), .PEC_FAIL_I(ev[5]),
    .COMM_OTHER_I(ev[6]), .FAN1_FAULT_I(ev[7]), .FAN2_FAULT_I(ev[8]), .FAN1_OVR_I(ev[9]),
    .FAN2_OVR_I(ev[10]), .RESTART_I(restart), .ALERT_N_O(alert_n), .OUTPUT_EN_O(out_en));
  function automatic logic [15:0] def_of(input logic [7:0] c);
    case (c)
      8'h42: def_of = 16'hA100;
      8'h43: def_of = 16'h5900;
      8'h44: def_of = 16'h5500;
      8'h47: def_of = 16'h00F8;
      8'h55: def_of = 16'h021C;
      8'h58: def_of = 16'h0154;
      8'h59: def_of = 16'h0136;
      8'h45, 8'h50, 8'h56, 8'h5A: def_of = 16'h00C0;
      default: def_of = 16'h0000;
    endcase
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    u_host.read(c, got);
    chk($sformatf("reg %h", c), e, got);
  endtask
  task automatic do_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    do_reset();
    foreach (codes[i]) rdchk(codes[i], def_of(codes[i]));
    chk("alert idle", 16'h0001, {15'h0, alert_n});
    u_host.cmd(1'b0, 8'h45, 16'h0012);
    rdchk(8'h45, 16'h00C0);
    u_host.cmd(1'b0, 8'h45, 16'h0080);
    rdchk(8'h45, 16'h0080);
    u_host.cmd(1'b0, 8'h47, 16'h0080);
    rdchk(8'h47, 16'h00F8);
    u_host.cmd(1'b0, 8'h58, 16'h0150);
    rdchk(8'h58, 16'h0154);
    u_host.cmd(1'b0, 8'h58, 16'h0160);
    rdchk(8'h58, 16'h0160);
    u_host.cmd(1'b0, 8'h55, 16'h0300);
    rdchk(8'h55, 16'h021C);
    u_host.cmd(1'b0, 8'h56, 16'h0080);
    rdchk(8'h56, 16'h00C0);
    rdchk(8'h7E, 16'h00C0);
    rdchk(8'h78, 16'h0002);
    u_host.cmd(1'b1, 8'h45, 16'h00C0);
    #1 chk("store", 16'h0145, {7'h0, nvwe, nvcode});
    chk("store data", 16'h0080, nvdata);
    // Load pulse reuses the code and data the host left standing
    @(posedge clk) ev <= 13'h0800;
    @(posedge clk) ev <= 13'h0000;
    rdchk(8'h45, 16'h00C0);
    rdchk(8'h46, 16'h0100);
    u_host.cmd(1'b0, 8'h46, 16'h0180);
    rdchk(8'h46, 16'h0180);
    @(posedge clk) hl <= 1'b1;
    rdchk(8'h46, 16'h0200);
    u_host.cmd(1'b0, 8'h46, 16'h0300);
    rdchk(8'h46, 16'h0300);
    @(posedge clk) hl <= 1'b0;
    rdchk(8'h46, 16'h0180);
    do_reset();
    @(posedge clk) vout <= 16'hA101;
    @(posedge clk) vout <= 16'h7D00;
    #1 chk("alert ov", 16'h0000, {15'h0, alert_n});
    rdchk(8'h7A, 16'h0040);
    @(posedge clk) {vout, ev} <= {16'h54FF, 13'h1000};
    @(posedge clk) {vout, ev} <= {16'h7D00, 13'h0000};
    #1 chk("uv masked", 16'h0001, {15'h0, out_en});
    rdchk(8'h7A, 16'h0060);
    @(posedge clk) vout <= 16'h54FF;
    @(posedge clk) vout <= 16'h7D00;
    #1 chk("uv off", 16'h0000, {15'h0, out_en});
    rdchk(8'h7A, 16'h0070);
    do_reset();
    @(posedge clk) temp <= 16'h0060;
    @(posedge clk) temp <= 16'h0020;
    #1 chk("ot off", 16'h0000, {15'h0, out_en});
    repeat (HC - 1) @(posedge clk);
    #1 chk("hiccup", 16'h0000, {15'h0, out_en});
    @(posedge clk);
    #1 chk("hiccup end", 16'h0001, {15'h0, out_en});
    rdchk(8'h7D, 16'h00C0);
    u_host.cmd(1'b0, 8'h50, 16'h0080);
    @(posedge clk) temp <= 16'h0060;
    @(posedge clk) temp <= 16'h0020;
    repeat (3 * HC) @(posedge clk);
    #1 chk("ot latched", 16'h0000, {15'h0, out_en});
    @(posedge clk) restart <= 1'b1;
    @(posedge clk) restart <= 1'b0;
    @(posedge clk);
    #1 chk("restart", 16'h0001, {15'h0, out_en});
    rdchk(8'h7D, 16'h0000);
    @(posedge clk) ev <= 13'h018C;
    @(posedge clk) ev <= 13'h0000;
    rdchk(8'h81, 16'h00C0);
    rdchk(8'h7C, 16'h0004);
    rdchk(8'h7B, 16'h0008);
    // Remaining event inputs held high; low-line warning crossed once
    @(posedge clk) {iout, ev} <= {16'h00F8, 13'h0673};
    @(posedge clk) iout <= 16'h0000;
    rdchk(8'h7A, 16'h0080);
    rdchk(8'h7B, 16'h002C);
    rdchk(8'h7C, 16'h0044);
    rdchk(8'h7E, 16'h0022);
    rdchk(8'h81, 16'h00CC);
    rdchk(8'h79, 16'hE422);
    @(posedge clk) ev <= 13'h0000;
    rdchk(8'h7B, 16'h0028);
    @(posedge clk) vin <= 16'h0135;
    repeat (2 * HC) @(posedge clk);
    #1 chk("vin uv off", 16'h0000, {15'h0, out_en});
    @(posedge clk) vin <= 16'h0170;
    @(posedge clk);
    #1 chk("vin back", 16'h0001, {15'h0, out_en});
    rdchk(8'h7C, 16'h007C);
    repeat (16) begin
      rnd = 16'($random(seed));
      u_host.cmd(1'b0, 8'h51, rnd);
      rdchk(8'h51, rnd);
    end
    complete_run();
  end
endmodule
